// ---- rtl/dcpg_pkg.sv ----
// Purpose: shared constants for the dual clock pulse generator
// Assumes: one 50 MHz system clock; register port with 1-cycle read data
// Notes: register offsets here are local choices
package dcpg_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned SYS_PRE_W = 13;
  localparam int unsigned SUB_PRE_W = 5;
  localparam int unsigned SUB_DIV4_W = 2;
  // register map
  localparam logic [3:0] OFF_OSC_CTRL = 4'h0;
  localparam logic [3:0] OFF_TIMER_A_MODE = 4'h1;
  localparam logic [3:0] OFF_POWER_MODE = 4'h2;
  // oscillator control fields
  localparam int unsigned BIT_SUB_HALT = 7;
  localparam int unsigned BIT_RSV6 = 6;
  localparam int unsigned BIT_RSV_HI = 5;
  localparam int unsigned BIT_RSV_LO = 3;
  localparam int unsigned BIT_PIN_FLAG = 2;
  localparam int unsigned BIT_OSC_FLAG = 1;
  localparam int unsigned BIT_RSV0 = 0;
  localparam logic [2:0] RSV_RESET = 3'h0;
  // timer a mode fields
  localparam int unsigned BIT_TA_CLR_HI = 3;
  localparam int unsigned BIT_TA_CLR_LO = 2;
  // power modes
  typedef enum logic [2:0] {
    PM_ACTIVE_HIGH,
    PM_ACTIVE_MED,
    PM_SLEEP,
    PM_STANDBY,
    PM_WATCH,
    PM_SUBACTIVE,
    PM_SUBSLEEP
  } dcpg_pmode_t;
  localparam logic [12:0] SYS_PRE_RESET = 13'h0000;
  localparam logic [4:0] SUB_PRE_RESET = 5'h00;
  localparam logic [1:0] SUB_DIV4_RESET = 2'h0;
  localparam logic [1:0] SUB_DIV4_LAST = 2'h3;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
endpackage

// ---- rtl/dcpg_top.sv ----
// Purpose: dual clock pulse generator: prescalers and oscillator control
// Assumes: subclock and event pin arrive asynchronously; sampled by two flops
// Notes: subclock edges are detected in the system clock domain
// Behaviour
// [R01] system prescaler gives taps from divide-by-8192 down to divide-by-2
// [R02] subclock prescaler gives taps from subclock/128 up to subclock/8
// [R03] control bit 7 halts subclock oscillator when 1; resets 0; read/write
// [R04] software sets halt bit only in active high or medium speed mode
// [R05] control bit 6 is reserved and always reads zero
// [R06] control bits 5..3 are reserved storage, reset zero, no effect
// [R07] read-only bit 2 shows event pin level sampled at reset
// [R08] read-only bit 1 shows which system oscillator drives the clock
// [R09] software never writes 1 to control bit 0
// [R10] pin low enables external oscillator; pin high enables on-chip one
// [R11] software waits stabilization time after re-enabling the subclock
// [R12] flash program or erase only with external oscillator selected
// [R13] system prescaler is a 13-bit counter, clear at reset, counts after
// [R14] system prescaler stops and clears in standby, watch, subactive, subsleep
// [R15] subclock prescaler is 5-bit on subclock/4, runs in all low-power modes
// [R16] writing ones to both timer-a clear bits resets subclock prescaler
// [R17] pin level latched at reset release, fixed until next reset
module dcpg_top (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // pins and mode
  input wire logic async_event_pin_in,
  input wire logic subclock_in,
  input wire logic [2:0] power_mode_in,
  // clock controls and taps
  output logic sub_osc_en_out,
  output logic sys_osc_en_out,
  output logic onchip_osc_en_out,
  output logic [12:0] sys_taps_out,
  output logic [4:0] sub_taps_out
);
  logic [12:0] sys_pre_ff;
  logic [12:0] nxt_sys_pre;
  logic [1:0] sub_div4_ff;
  logic [4:0] sub_pre_ff;
  logic [4:0] nxt_sub_pre;
  logic [1:0] sub_sync_ff;
  logic sub_prev_ff;
  logic [1:0] pin_sync_ff;
  logic in_reset_ff;
  logic sub_halt_ff;
  logic [2:0] rsv_ff;
  logic rsv0_ff;
  logic pin_flag_ff;
  logic [7:0] rdata_ff;
  logic sub_osc_en_ff;
  logic sys_osc_en_ff;
  logic onchip_osc_en_ff;

  // register decode
  wire wr_ctrl = reg_wr_in && (reg_addr_in == dcpg_pkg::OFF_OSC_CTRL);
  wire wr_tma = reg_wr_in && (reg_addr_in == dcpg_pkg::OFF_TIMER_A_MODE);
  wire sub_pre_clr = wr_tma && reg_wdata_in[dcpg_pkg::BIT_TA_CLR_HI]
    && reg_wdata_in[dcpg_pkg::BIT_TA_CLR_LO]; // R16
  wire sys_stop = (power_mode_in == dcpg_pkg::PM_STANDBY)
    || (power_mode_in == dcpg_pkg::PM_WATCH)
    || (power_mode_in == dcpg_pkg::PM_SUBACTIVE)
    || (power_mode_in == dcpg_pkg::PM_SUBSLEEP); // R14
  wire sub_rise = sub_sync_ff[1] && !sub_prev_ff;
  wire sub_tick = sub_rise && (sub_div4_ff == dcpg_pkg::SUB_DIV4_LAST); // R15
  wire [7:0] ctrl_val = {sub_halt_ff, 1'b0, rsv_ff, pin_flag_ff,
    pin_flag_ff, rsv0_ff}; // R05 R07 R08
  wire [7:0] rd_mux = (reg_addr_in == dcpg_pkg::OFF_OSC_CTRL) ? ctrl_val
    : (reg_addr_in == dcpg_pkg::OFF_POWER_MODE) ? {5'h0_0, power_mode_in}
    : dcpg_pkg::ZERO_BYTE;

  // next prescaler values
  assign nxt_sys_pre = sys_stop ? dcpg_pkg::SYS_PRE_RESET
    : sys_pre_ff + 13'h0001; // R13 R14
  assign nxt_sub_pre = sub_pre_clr ? dcpg_pkg::SUB_PRE_RESET
    : sub_tick ? sub_pre_ff + 5'h01 : sub_pre_ff; // R15 R16

  // synchronisers for subclock and event pin
  always_ff @(posedge clk_sys_in)
  begin
    sub_sync_ff <= {sub_sync_ff[0], subclock_in};
    pin_sync_ff <= {pin_sync_ff[0], async_event_pin_in};
    sub_prev_ff <= sub_sync_ff[1];
  end

  // prescalers
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      sys_pre_ff <= dcpg_pkg::SYS_PRE_RESET; // R13
      sub_pre_ff <= dcpg_pkg::SUB_PRE_RESET;
      sub_div4_ff <= dcpg_pkg::SUB_DIV4_RESET;
    end
    else
    begin
      sys_pre_ff <= nxt_sys_pre; // R01
      sub_pre_ff <= nxt_sub_pre; // R02
      if (sub_pre_clr)
        sub_div4_ff <= dcpg_pkg::SUB_DIV4_RESET;
      else if (sub_rise)
        sub_div4_ff <= sub_div4_ff + 2'h1;
    end
  end

  // pin level capture at the first edge after reset release
  always_ff @(posedge clk_sys_in)
  begin
    in_reset_ff <= !rst_n_in;
    if (in_reset_ff && rst_n_in)
      pin_flag_ff <= pin_sync_ff[1]; // R17 R07
  end

  // oscillator control register
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      sub_halt_ff <= 1'b0;
      rsv_ff <= dcpg_pkg::RSV_RESET;
      rsv0_ff <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      sub_halt_ff <= reg_wdata_in[dcpg_pkg::BIT_SUB_HALT]; // R03 R04
      rsv_ff <= reg_wdata_in[dcpg_pkg::BIT_RSV_HI:dcpg_pkg::BIT_RSV_LO]; // R06
      rsv0_ff <= reg_wdata_in[dcpg_pkg::BIT_RSV0]; // R09
    end
  end

  // registered outputs
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      rdata_ff <= dcpg_pkg::ZERO_BYTE;
    else
      rdata_ff <= reg_rd_in ? rd_mux : dcpg_pkg::ZERO_BYTE;
    sub_osc_en_ff <= rst_n_in && !sub_halt_ff; // R03
    sys_osc_en_ff <= !pin_flag_ff; // R10
    onchip_osc_en_ff <= pin_flag_ff; // R10 R08
  end

  assign reg_rdata_out = rdata_ff;
  assign sub_osc_en_out = sub_osc_en_ff;
  assign sys_osc_en_out = sys_osc_en_ff;
  assign onchip_osc_en_out = onchip_osc_en_ff;
  assign sys_taps_out = sys_pre_ff;
  assign sub_taps_out = sub_pre_ff;
endmodule

// ---- verif/dcpg_sva.sv ----
// Purpose: port checks for dcpg_top
// Assumes: reset held at least 5 cycles
// Notes: bound to every dcpg_top
module dcpg_sva (
  // clock, reset, register port
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  // mode, enables, taps
  input wire logic [2:0] power_mode_in,
  input wire logic sys_osc_en_out,
  input wire logic onchip_osc_en_out,
  input wire logic [12:0] sys_taps_out,
  input wire logic [4:0] sub_taps_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  a_sys_count_step: assert property (power_mode_in < 3'h3 |=>
    sys_taps_out == $past(sys_taps_out) + 13'h0001) else $error("sys count step");
  a_sys_low_clear: assert property (power_mode_in > 3'h2 |=>
    sys_taps_out == 13'h0000) else $error("sys count not cleared");
  a_rsv_six_zero: assert property ($past(reg_rd_in) && $past(reg_addr_in) == 4'h0
    |-> !reg_rdata_out[6]) else $error("bit 6 set");
  a_rdata_idle_zero: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data outside read");
  a_flag_osc_match: assert property ($past(reg_rd_in) && $past(reg_addr_in) == 4'h0
    |-> reg_rdata_out[2:1] == {2{onchip_osc_en_out}} && sys_osc_en_out != onchip_osc_en_out)
    else $error("flag and oscillator disagree");
  a_select_held: assert property ($past(rst_n_in, 4) && $past(rst_n_in) |->
    $stable({sys_osc_en_out, onchip_osc_en_out})) else $error("selection moved");
  a_sub_clear_now: assert property (reg_wr_in && reg_addr_in == 4'h1 &&
    reg_wdata_in[3:2] == 2'b11 |=> sub_taps_out == 5'h00) else $error("sub not cleared");
  a_sub_step_one: assert property ($changed(sub_taps_out) |->
    sub_taps_out == $past(sub_taps_out) + 5'h01 || sub_taps_out == 5'h00)
    else $error("sub count jumped");
endmodule
bind dcpg_top dcpg_sva chk_u (.clk_sys_in, .rst_n_in, .reg_addr_in, .reg_wdata_in,
  .reg_wr_in, .reg_rd_in, .reg_rdata_out, .power_mode_in, .sys_osc_en_out,
  .onchip_osc_en_out, .sys_taps_out, .sub_taps_out);

// ---- verif/dcpg_xtal_model.sv ----
// Purpose: subclock crystal seen by the block
// Assumes: sped up so prescaler steps stay short
// Notes: a halted crystal stands still low
module dcpg_xtal_model #(parameter int HALF_NS = 200) (
  // enable in, clock out
  input wire logic en_in,
  output logic sub_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial sub_out = 1'b0;
  // oscillates only while enabled
  always #(HALF_NS) sub_out = en_in ? !sub_out : 1'b0;
endmodule

// ---- verif/tb_top.sv ----
// Purpose: self-checking bench for dcpg_top
// Assumes: 50 MHz clock, fast crystal model
// Notes: reference keeps the writable control bits
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, pin = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wd = 8'h00, rdata, ref_q = 8'h00, flag_q = 8'h00;
  logic [2:0] mode = 3'h0;
  logic [12:0] staps, exp_s;
  logic [4:0] wtaps;
  logic [31:0] seed = 32'h3ff9;
  logic sub_clk, sub_en, sys_en, chip_en;
  int failures = 0, checks = 0, n;
  // clock
  always #10 clk = ~clk;
  dcpg_top dut_u (.clk_sys_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wd),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .async_event_pin_in(pin),
    .subclock_in(sub_clk), .power_mode_in(mode), .sub_osc_en_out(sub_en),
    .sys_osc_en_out(sys_en), .onchip_osc_en_out(chip_en), .sys_taps_out(staps),
    .sub_taps_out(wtaps));
  dcpg_xtal_model xtal_u (.en_in(sub_en), .sub_out(sub_clk));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [12:0] g, input logic [12:0] e);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic close_out();
    $display("failures %0d checks %0d", failures, checks);
    if (failures == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one write or read cycle; read data sampled the cycle after
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask
  task automatic reset_to(input logic p);
    pin <= p;
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    flag_q = p ? 8'h06 : 8'h00;
  endtask
  // watchdog
  initial
  begin
    #1000000;
    failures++;
    close_out();
  end
  // main sequence
  initial
  begin
    reset_to(1'b0);
    bus(1'b0, 4'h0, 8'h00);
    chk(13'(rdata), 13'h0000);
    chk(13'({sys_en, chip_en}), 13'h0002);
    repeat (8)
    begin
      seed = lfsr(seed);
      bus(1'b1, 4'h0, seed[7:0] & 8'hfe);
      ref_q = seed[7:0] & 8'hb8;
      pin <= seed[3];
      bus(1'b0, 4'h0, 8'h00);
      chk(13'(rdata), 13'(ref_q | flag_q));
      chk(13'(sub_en), 13'(!ref_q[7]));
    end
    bus(1'b1, 4'h0, 8'h00);
    bus(1'b0, 4'hf, 8'h00);
    chk(13'(rdata), 13'h0000);
    // subclock restarted: let it settle before the prescaler is used
    repeat (40) @(posedge clk);
    for (int m = 0; m < 7; m++)
    begin
      mode <= m[2:0];
      repeat (2) @(posedge clk);
      #1 exp_s = (m > 2) ? 13'h0000 : staps + 13'h0001;
      @(posedge clk);
      #1 chk(staps, exp_s);
      bus(1'b0, 4'h2, 8'h00);
      chk(13'(rdata), 13'(m));
    end
    mode <= 3'h0;
    bus(1'b1, 4'h1, 8'h0c);
    chk(13'(wtaps), 13'h0000);
    for (n = 0; n < 300 && wtaps == 5'h00; n++)
      @(posedge clk) #1;
    chk(13'(n > 55 && n < 90 && wtaps == 5'h01), 13'h0001);
    reset_to(1'b1);
    pin <= 1'b0;
    bus(1'b0, 4'h0, 8'h00);
    chk(13'(rdata), 13'h0006);
    chk(13'({sys_en, chip_en}), 13'h0001);
    close_out();
  end
endmodule
